/* rtl/asp_pkg.sv */
// Purpose: constants for the converter serial register-access port
// Assumes: one 50 MHz system clock, serial pins sampled through two flops
// Notes:   Functional notes follow
package asp_pkg;
    localparam int          ASP_WORD_BITS   = 24;
    localparam int          ASP_CNT_W       = 5;
    localparam logic [4:0]  ASP_BITS_24     = 5'h18;
    localparam logic [4:0]  ASP_BITS_16     = 5'h10;
    localparam logic [23:0] ASP_CTRL_RST    = 24'h000000;
    localparam logic [23:0] ASP_CAL_RST     = 24'h000000;
    localparam int          ASP_CLK_MHZ     = 50;
    localparam int          ASP_SCLK_NS     = 400;
    // half period of generated serial clock in system cycles
    localparam int          ASP_HALF_CYC    = (ASP_SCLK_NS * ASP_CLK_MHZ) / 2000;
    typedef enum logic [1:0] {
        ASP_IDLE  = 2'b00,
        ASP_READ  = 2'b01,
        ASP_WRITE = 2'b10,
        ASP_DONE  = 2'b11
    } asp_state_t;
endpackage

/* rtl/asp_sync.sv */
// Purpose: two-flop synchroniser for a bus of asynchronous pins
// Assumes: inputs are levels from outside the sys_clk domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module asp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    // two stage capture
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

/* rtl/asp_port.sv */
// Purpose: serial register-access port, self and external clock modes
// Assumes: pins asynchronous to sys_clk; serial clock well below sys_clk/4
// Notes:   output word comes from the converter as a one-cycle strobe
`timescale 1ns/1ps
module asp_port
    import asp_pkg::*;
#(
    parameter int          HALF_CYC  = ASP_HALF_CYC,
    parameter logic [4:0]  OUT_BITS  = ASP_BITS_24
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        mode_pin,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    input  wire logic        read_frame_n,
    input  wire logic        write_frame_n,
    input  wire logic        register_select,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_oe,
    output logic             data_ready_n,
    input  wire logic        conv_valid,
    input  wire logic [23:0] conv_word,
    input  wire logic [23:0] cal_word,
    output logic [23:0]      ctrl_reg,
    output logic [23:0]      cal_reg,
    output logic             cal_load
);
    // synchronised pins: mode, clock, read frame, write frame, select, data
    logic [5:0] pin_s;
    asp_sync #(.W(6)) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({mode_pin, sclk_in, read_frame_n, write_frame_n,
                    register_select, serial_data_in}),
        .sync_out (pin_s)
    );
    wire mode_s = pin_s[5];
    wire xclk_s = pin_s[4];
    wire rfs_s  = pin_s[3];
    wire tfs_s  = pin_s[2];
    wire sel_s  = pin_s[1];
    wire din_s  = pin_s[0];

    asp_state_t   state_ff, nxt_state;
    logic         xclk_d_ff, rfs_d_ff, tfs_d_ff;
    logic [23:0]  out_reg_ff;
    logic [23:0]  shift_ff;
    logic [4:0]   cnt_ff;
    logic [4:0]   len_ff;
    logic         sel_ff;
    logic         is_out_ff;
    logic [15:0]  div_ff;
    logic         gclk_ff;
    logic         data_ready_n_ff;

    // serial clock source: generated in self mode, pin in external mode
    wire self_mode = mode_s;
    wire div_hit   = (div_ff == 16'(HALF_CYC - 1));
    wire run_gen   = self_mode && (state_ff == ASP_WRITE);
    wire g_rise    = run_gen && div_hit && !gclk_ff;
    wire g_fall    = run_gen && div_hit &&  gclk_ff;
    wire x_rise    = !self_mode && xclk_s && !xclk_d_ff;
    wire x_fall    = !self_mode && !xclk_s && xclk_d_ff;
    wire s_rise    = self_mode ? g_rise : x_rise;
    wire s_fall    = self_mode ? g_fall : x_fall;
    wire rfs_fall  = !rfs_s && rfs_d_ff;
    wire tfs_fall  = !tfs_s && tfs_d_ff;

    // read target: select high = output (data_ready_n low) or cal, low = control
    wire rd_out    = sel_s && !data_ready_n_ff;
    wire rd_cal    = sel_s &&  data_ready_n_ff;
    // select-high read with data ready high transfers the calibration word
    wire rd_ok     = !self_mode && rfs_fall && !(rd_out && data_ready_n_ff);
    wire wr_go     = tfs_fall;
    wire last_bit  = (cnt_ff == len_ff - 5'h01);
    wire rd_shift  = (state_ff == ASP_READ) && !rfs_s && s_fall;
    wire rd_end    = rd_shift && (cnt_ff == len_ff);
    wire wr_take   = (state_ff == ASP_WRITE) && !tfs_s && s_rise;
    wire wr_end    = wr_take && last_bit;

    // transfer sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ASP_IDLE:  begin
                if (wr_go) begin
                    nxt_state = ASP_WRITE;
                end else if (rd_ok) begin
                    nxt_state = ASP_READ;
                end
            end
            ASP_READ:  begin
                if (rd_end) begin
                    nxt_state = ASP_IDLE;
                end
            end
            ASP_WRITE: begin
                if (wr_end) begin
                    nxt_state = self_mode ? ASP_DONE : ASP_IDLE;
                end
            end
            ASP_DONE:  begin
                if (!self_mode || (div_hit && gclk_ff)) begin
                    nxt_state = ASP_IDLE;
                end
            end
        endcase
    end

    // edge history and state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= ASP_IDLE;
            xclk_d_ff <= 1'b0;
            rfs_d_ff  <= 1'b1;
            tfs_d_ff  <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            xclk_d_ff <= xclk_s;
            rfs_d_ff  <= rfs_s;
            tfs_d_ff  <= tfs_s;
        end
    end

    // generated clock divider, runs only during a self write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff  <= '0;
            gclk_ff <= 1'b0;
        end else if ((state_ff == ASP_WRITE || state_ff == ASP_DONE) && self_mode) begin
            div_ff  <= div_hit ? '0 : div_ff + 16'h0001;
            gclk_ff <= div_hit ? !gclk_ff : gclk_ff;
        end else begin
            div_ff  <= '0;
            gclk_ff <= 1'b0;
        end
    end

    // shift register, bit counter, target latch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_ff  <= '0;
            cnt_ff    <= '0;
            len_ff    <= ASP_BITS_24;
            sel_ff    <= 1'b0;
            is_out_ff <= 1'b0;
        end else if (state_ff == ASP_IDLE && wr_go) begin
            cnt_ff    <= '0;
            len_ff    <= ASP_BITS_24;
            sel_ff    <= sel_s;
            is_out_ff <= 1'b0;
        end else if (state_ff == ASP_IDLE && rd_ok) begin
            // MSB presented on the frame fall
            shift_ff  <= rd_out ? out_reg_ff : (sel_s ? cal_word : ctrl_reg);
            cnt_ff    <= 5'h01;
            len_ff    <= rd_out ? OUT_BITS : ASP_BITS_24;
            is_out_ff <= rd_out;
        end else if (rd_shift && !rd_end) begin
            shift_ff  <= {shift_ff[22:0], 1'b0};
            cnt_ff    <= cnt_ff + 5'h01;
        end else if (wr_take) begin
            shift_ff  <= {shift_ff[22:0], din_s};
            cnt_ff    <= cnt_ff + 5'h01;
        end
    end

    // target registers update only after the full word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= ASP_CTRL_RST;
            cal_reg  <= ASP_CAL_RST;
            cal_load <= 1'b0;
        end else begin
            cal_load <= wr_end && sel_ff;
            if (wr_end && !sel_ff) begin
                ctrl_reg <= {shift_ff[22:0], din_s};
            end
            if (wr_end && sel_ff) begin
                cal_reg  <= {shift_ff[22:0], din_s};
            end
        end
    end

    // output register and data ready; writes never touch data ready
    wire out_busy = (state_ff == ASP_READ) && is_out_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg_ff <= '0;
            data_ready_n_ff    <= 1'b1;
        end else begin
            if (conv_valid) begin
                out_reg_ff <= conv_word;
            end
            if (rd_end && is_out_ff) begin
                data_ready_n_ff <= 1'b1;
            end else if (conv_valid && !out_busy) begin
                data_ready_n_ff <= 1'b0;
            end
        end
    end

    // pin drivers, all registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_out        <= 1'b0;
            sclk_oe         <= 1'b0;
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
            data_ready_n    <= 1'b1;
        end else begin
            sclk_out        <= gclk_ff;
            sclk_oe         <= run_gen || (state_ff == ASP_DONE);
            serial_data_out <= shift_ff[23];
            serial_data_oe  <= (state_ff == ASP_READ) && !rfs_s && !rd_end;
            data_ready_n    <= data_ready_n_ff;
        end
    end

    a_data_ready_n_write_free: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_WRITE && !conv_valid) |=> $stable(data_ready_n_ff))
        else $error("data ready moved during write");
    a_ctrl_after_24: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$stable(ctrl_reg) |-> $past(wr_end) && !$past(sel_ff))
        else $error("control register changed early");
    a_data_ready_n_high_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_end && is_out_ff) |=> data_ready_n_ff ##1 data_ready_n)
        else $error("data ready not released after read");
    a_drop_midread: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (out_busy && conv_valid && !rd_end) |=> $stable(data_ready_n_ff))
        else $error("word signalled during read");
    a_no_xfer_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_IDLE && rfs_fall && sel_s && data_ready_n_ff && !wr_go) |=>
        state_ff == ASP_IDLE || !is_out_ff)
        else $error("output read started with data ready high");
    a_sclk_off_ext: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !self_mode && !$past(self_mode) |=> !sclk_oe)
        else $error("serial clock driven in external mode");
    a_data_off_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rfs_s |=> !serial_data_oe)
        else $error("data driven while frame high");
    a_gen_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_DONE && nxt_state == ASP_IDLE) |=> ##1 !sclk_oe)
        else $error("serial clock still driven after write");

    // a calibration write leaves the control register alone
    a_cal_keeps_ctrl: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_end && sel_ff) |=> $stable(ctrl_reg))
        else $error("control register hit by calibration write");

    // a control write stores the assembled word
    a_ctrl_word_in: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_end && !sel_ff) |=> ctrl_reg == $past({shift_ff[22:0], din_s}))
        else $error("control register holds wrong word");

    // calibration load strobe follows a calibration write
    a_cal_load_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_end && sel_ff) |=> cal_load)
        else $error("calibration load strobe missing");

    // calibration load strobe lasts one cycle
    a_cal_load_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cal_load |=> !cal_load)
        else $error("calibration load strobe too long");

    // a write frame fall while idle starts a write
    a_write_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_IDLE && wr_go) |=> state_ff == ASP_WRITE)
        else $error("write frame fall ignored");

    // self mode write drives the serial clock pin
    a_self_clk_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_WRITE && self_mode) |=> sclk_oe)
        else $error("generated clock not driven during write");

    // each taken bit advances the counter by one
    a_bit_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_take |=> cnt_ff == $past(cnt_ff) + 5'h01)
        else $error("write bit count did not advance");

    // bit counter never passes a full word
    a_cnt_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cnt_ff <= ASP_BITS_24))
        else $error("bit counter overran word");

    // divider stays inside its half period
    a_div_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (div_ff < 16'(HALF_CYC)))
        else $error("clock divider overran");

    // no generated edges while the pin clock is in use
    a_ext_no_gen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !self_mode |-> (!g_rise && !g_fall))
        else $error("generated edge in external mode");

    // pin clock edges ignored in self mode
    a_self_no_xclk: assert property (@(posedge sys_clk) disable iff (!rst_n)
        self_mode |-> (!x_rise && !x_fall))
        else $error("pin clock edge used in self mode");

    // output read length follows the output word size
    a_out_read_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_IDLE && rd_ok && rd_out && !wr_go) |=> len_ff == OUT_BITS)
        else $error("output read length wrong");

    // register reads are always a full word
    a_reg_read_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_IDLE && rd_ok && !rd_out && !wr_go) |=>
        (len_ff == ASP_BITS_24 && !is_out_ff))
        else $error("register read length wrong");

    // register reads leave data ready alone
    a_reg_read_data_ready_n: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_READ && !is_out_ff && !conv_valid) |=> $stable(data_ready_n_ff))
        else $error("data ready moved by register read");

    // first bit out is the top bit of the loaded word
    a_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_IDLE && rd_ok && !wr_go) |=>
        ##1 serial_data_out == $past(shift_ff[23]))
        else $error("read did not start with top bit");

    // each read falling edge but the last moves the word up one place
    a_shift_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_shift && !rd_end) |=> shift_ff == {$past(shift_ff[22:0]), 1'b0})
        else $error("read shift wrong");

    // last falling edge ends the read
    a_read_end_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_end |=> state_ff == ASP_IDLE)
        else $error("read did not end");

    // data line released at read end
    a_oe_off_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_end |=> !serial_data_oe)
        else $error("data line still driven after read");

    // paused read keeps its bit position
    a_pause_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_READ && rfs_s) |=> $stable(cnt_ff))
        else $error("read advanced while paused");

    // paused write keeps its bit position
    a_write_pause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_ff == ASP_WRITE && tfs_s) |=> $stable(cnt_ff))
        else $error("write advanced while paused");

    // data ready stays low until the output word is all read
    a_stay_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (out_busy && !rd_end && !data_ready_n_ff) |=> !data_ready_n_ff)
        else $error("data ready rose mid read");

    // data ready pin follows its flop one cycle later
    a_data_ready_n_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> data_ready_n == $past(data_ready_n_ff))
        else $error("data ready pin out of step");
endmodule

/* verification/asp_host.sv */
// Purpose: host serial port model facing the converter port
// Assumes: link clock 160 ns made here, 8 system cycles
// Notes:   released data line reads as the inverse of its last value
`timescale 1ns/1ps
module asp_host (
    input  wire logic sys_clk,
    input  wire logic mode_pin,
    input  wire logic sclk_out,
    input  wire logic sclk_oe,
    input  wire logic serial_data_out,
    input  wire logic serial_data_oe,
    output logic      sclk_line,
    output logic      read_frame_n,
    output logic      write_frame_n,
    output logic      register_select,
    output logic      serial_data_in
);
    logic sclk_drv = 1'b0;
    logic last_q   = 1'b0;
    logic line;
    logic pz_oe;
    // pull-up in self mode, host clock in external mode
    assign sclk_line = sclk_oe ? sclk_out : (mode_pin | sclk_drv);
    assign line      = serial_data_oe ? serial_data_out : ~last_q;
    always @(posedge sys_clk) last_q <= line;
    initial begin
        read_frame_n    = 1'b1;
        write_frame_n   = 1'b1;
        register_select = 1'b0;
        serial_data_in  = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one clock period: data set mid low phase, sampled late in high phase
    task automatic bit_x(input logic tx, output logic rx);
        wt(2);
        serial_data_in <= tx;
        wt(2);
        sclk_drv <= 1'b1;
        wt(3);
        @(negedge sys_clk) rx = line;
        wt(1);
        sclk_drv <= 1'b0;
    endtask
    // external-clock frame of 24 bits, paused after bit pz
    task automatic xfer(input logic wr, input logic sel, input logic [23:0] d,
                        input int pz, output logic [23:0] q);
        register_select <= sel;
        if (wr) write_frame_n <= 1'b0;
        else read_frame_n <= 1'b0;
        wt(8);
        for (int i = 23; i >= 0; i--) begin
            bit_x(d[i], q[i]);
            if (i == pz) begin
                wt(2);
                write_frame_n <= 1'b1;
                read_frame_n <= 1'b1;
                wt(8);
                @(negedge sys_clk) pz_oe = serial_data_oe;
                if (wr) write_frame_n <= 1'b0;
                else read_frame_n <= 1'b0;
                wt(8);
            end
        end
        wt(8); // clock held low between transfers
        write_frame_n <= 1'b1;
        read_frame_n <= 1'b1;
        wt(8);
    endtask
    // self-clock write: next bit after each falling edge of the device clock
    task automatic self_wr(input logic sel, input logic [23:0] d, output int n);
        logic prev;
        logic fl;
        logic oe;
        prev = 1'b0;
        oe = 1'b1;
        n = 0;
        register_select <= sel;
        serial_data_in <= d[23];
        write_frame_n <= 1'b0;
        for (int g = 0; g < 1000 && !(n == 24 && !oe); g++) begin
            @(negedge sys_clk);
            if (sclk_oe && sclk_line && !prev) n++;
            fl = sclk_oe && !sclk_line && prev && n < 24;
            prev = sclk_line;
            oe = sclk_oe;
            @(posedge sys_clk);
            if (fl) serial_data_in <= d[23 - n];
        end
        write_frame_n <= 1'b1;
        wt(8);
    endtask
endmodule

/* verification/testbench.sv */
// Purpose: self-checking bench for the serial register-access port
// Assumes: host model moves bits, bench posts conversion words
// Notes:   generated clock half period 8 cycles, leaves room for data sync
`timescale 1ns/1ps
module testbench;
    import asp_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        mode_pin = 1'b0;
    logic        conv_valid = 1'b0;
    logic [23:0] conv_word = 24'h000000;
    logic [23:0] cal_word = 24'h5a0f33;
    logic [23:0] q;
    logic        sclk_out, sclk_oe, sclk_line, rfs_n, wfs_n, sel, sdi;
    logic        sdo, sdo_oe, data_ready_n, cal_load;
    logic [23:0] ctrl_reg, cal_reg;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;
    always #10 sys_clk = ~sys_clk;
    asp_port #(.HALF_CYC(8)) u_asp_port (.sys_clk(sys_clk), .rst_n(rst_n),
        .mode_pin(mode_pin), .sclk_in(sclk_line), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .read_frame_n(rfs_n), .write_frame_n(wfs_n), .register_select(sel),
        .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
        .data_ready_n(data_ready_n), .conv_valid(conv_valid), .conv_word(conv_word),
        .cal_word(cal_word), .ctrl_reg(ctrl_reg), .cal_reg(cal_reg), .cal_load(cal_load));
    asp_host host (.sys_clk(sys_clk), .mode_pin(mode_pin), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
        .sclk_line(sclk_line), .read_frame_n(rfs_n), .write_frame_n(wfs_n),
        .register_select(sel), .serial_data_in(sdi));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one-cycle conversion strobe
    task automatic post(input logic [23:0] w);
        conv_valid <= 1'b1;
        conv_word <= w;
        @(posedge sys_clk) conv_valid <= 1'b0;
        host.wt(8);
    endtask
    // external writes, the first one paused, data ready held low meanwhile
    task automatic t_ext_write;
        post(24'h0c0ffe);
        host.xfer(1'b1, 1'b0, 24'ha5c31e, 12, q);
        check(ctrl_reg, 24'ha5c31e);
        check(data_ready_n, 1'b0);
        host.xfer(1'b1, 1'b1, 24'h3c96f0, 30, q);
        check(cal_reg, 24'h3c96f0);
        check(ctrl_reg, 24'ha5c31e);
    endtask
    // output read of newest word, paused, with a word arriving mid read
    task automatic t_out_read;
        post(24'h9e3b57);
        check(data_ready_n, 1'b0);
        fork
            host.xfer(1'b0, 1'b1, 24'h000000, 10, q);
            begin host.wt(120); post(24'h777777); end
        join
        check(q, 24'h9e3b57);
        check(host.pz_oe, 1'b0);
        check(data_ready_n, 1'b1);
        check(sdo_oe, 1'b0);
    endtask
    // control and calibration reads leave data ready alone
    task automatic t_reg_read;
        cal_word <= 24'h2b7e19;
        host.wt(2);
        host.xfer(1'b0, 1'b1, 24'h000000, 30, q);
        check(q, 24'h2b7e19);
        check(data_ready_n, 1'b1);
        post(24'h4d2e61);
        host.xfer(1'b0, 1'b0, 24'h000000, 30, q);
        check(q, 24'ha5c31e);
        check(data_ready_n, 1'b0);
    endtask
    // self-clock write to the control register
    task automatic t_self_write;
        mode_pin <= 1'b1;
        host.wt(8);
        host.self_wr(1'b0, 24'h6b1d83, n);
        check(n, 24);
        check(sclk_oe, 1'b0);
        check(ctrl_reg, 24'h6b1d83);
        mode_pin <= 1'b0;
        host.wt(8);
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        host.wt(6);
        t_ext_write();
        t_out_read();
        t_reg_read();
        t_self_write();
        tally_and_finish();
    end
endmodule
